// *** sim/eepc_cpu_model.sv ***
// eepc_cpu_model: cpu-side master of the eepc_top register port
// assumes every task is entered just after a rising clock edge
`timescale 1ns/100ps
module eepc_cpu_model (
    // clock
    input wire logic sys_clk_i,
    // register port
    output eepc_pkg::eepc_bus_s bus_o,
    input wire logic [eepc_pkg::DATA_W-1:0] rdata_i
);
    import eepc_pkg::*;
    initial begin
        bus_o = '0;
    end
    // released lines flip so a stale address or datum is never mistaken for a request
    task automatic idle(input int n);
        bus_o <= '{addr: ~bus_o.addr, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b0};
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
        bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [BUS_AW-1:0] a, output logic [DATA_W-1:0] d);
        bus_o <= '{addr: a, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i);
        bus_o <= '{addr: ~a, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b0};
        #1 d = rdata_i;
        @(posedge sys_clk_i);
    endtask
endmodule // eepc_cpu_model

// *** sim/eepc_top_monitor.sv ***
// eepc_top_monitor: port-level checks on the register, pump and config outputs
// assumes one clock domain; bound to every eepc_top instance
`timescale 1ns/100ps
module eepc_top_monitor #(
    parameter int DEPTH = 512
) (
    // clock, reset and requests
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire eepc_pkg::eepc_bus_s bus_i,
    input wire logic stop_i,
    input wire logic wait_i,
    // answers
    input wire logic [eepc_pkg::DATA_W-1:0] rdata_o,
    input wire eepc_pkg::eepc_pump_s pump_o,
    input wire logic [eepc_pkg::DATA_W-1:0] mcu_config_bits_o
);
    import eepc_pkg::*;
    logic wr_ctl;
    logic rd_nv;
    logic arr_seen;
    logic [3:0] up_cnt;
    logic [2:0] quiet_cnt;
    assign wr_ctl = bus_i.wr && bus_i.addr == OFF_CONTROL;
    assign rd_nv = bus_i.rd && bus_i.addr == OFF_NV_CONFIG;
    // config may settle freely during the first cycles after release
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_cnt <= 4'h0;
        end else if (up_cnt != 4'hF) begin
            up_cnt <= up_cnt + 4'h1;
        end
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            arr_seen <= 1'b0;
        end else if (bus_i.wr && !bus_i.addr[CTRL_PAGE_BIT]) begin
            arr_seen <= 1'b1;
        end
    end
    // stop passes a synchroniser, so calm must last a few cycles
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            quiet_cnt <= 3'h0;
        end else if (stop_i || wr_ctl) begin
            quiet_cnt <= 3'h0;
        end else if (quiet_cnt != 3'h7) begin
            quiet_cnt <= quiet_cnt + 3'h1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    chk_pump_clk_src: assert property ($changed(pump_o.pump_bus_clk) |->
        $past(wr_ctl, 2) && $past(bus_i.wdata[B_PUMP_CLK], 2) == pump_o.pump_bus_clk)
        else $error("pump clock source changed without a control write");
    chk_power_down_src: assert property ($rose(pump_o.power_down) |->
        $past(wr_ctl && bus_i.wdata[B_POWER_DOWN], 2))
        else $error("power down rose without a control write");
    chk_stop_hv_off: assert property (stop_i [*5] |-> !pump_o.hv_on)
        else $error("high voltage still on in stop");
    chk_hv_needs_write: assert property ($rose(pump_o.hv_on) |-> arr_seen)
        else $error("high voltage without an array write");
    chk_latch_with_hv: assert property (bus_i.rd && bus_i.addr == OFF_CONTROL |=>
        !rdata_o[B_HV_EN] || rdata_o[B_LATCH])
        else $error("enable set with latch clear");
    chk_nv_reload: assert property (rd_nv ##1 1'b1 |=>
        mcu_config_bits_o == $past(rdata_o))
        else $error("config not reloaded by read");
    chk_cfg_cause: assert property ($changed(mcu_config_bits_o) |->
        up_cnt < 4'h6 || $past(rd_nv, 2))
        else $error("config changed without cause");
    chk_wait_keeps_hv: assert property (pump_o.hv_on && wait_i && quiet_cnt > 3'h3 |=>
        pump_o.hv_on)
        else $error("high voltage dropped in wait");
endmodule // eepc_top_monitor
bind eepc_top eepc_top_monitor #(.DEPTH(DEPTH)) i_mon (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .bus_i(bus_i), .stop_i(stop_i), .wait_i(wait_i),
    .rdata_o(rdata_o), .pump_o(pump_o), .mcu_config_bits_o(mcu_config_bits_o));

// *** sim/tb_top.sv ***
// tb_top: self-checking bench for eepc_top driven through the cpu model
// assumes the register map and field positions of eepc_pkg
`timescale 1ns/100ps
module tb_top;
    import eepc_pkg::*;
    localparam int HV_CYC = 20;
    localparam int LIMIT = 5000;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic stop_i = 1'b0;
    logic wait_i = 1'b0;
    eepc_bus_s bus;
    eepc_pump_s pump;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] cfg;
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] t;
    logic [DATA_W-1:0] d;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    eepc_top i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
        .stop_i(stop_i), .wait_i(wait_i), .pump_o(pump), .mcu_config_bits_o(cfg));
    eepc_cpu_model i_cpu (.sys_clk_i(sys_clk_i), .bus_o(bus), .rdata_i(rdata));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors = errors + 1;
            final_report();
        end
    end
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [BUS_AW-1:0] ad, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] v;
        i_cpu.rd(ad, v);
        chk(v, exp);
    endtask
    // outputs are looked at 1ns after the edge, then the caller is realigned to the next edge
    task automatic pump_chk(input logic [2:0] exp);
        #1 chk({5'h00, pump}, {5'h00, exp});
        @(posedge sys_clk_i);
    endtask
    task automatic nv_chk(input logic [DATA_W-1:0] exp);
        rd_chk(OFF_NV_CONFIG, exp);
        #1 chk(cfg, exp);
        @(posedge sys_clk_i);
    endtask
    function automatic logic [DATA_W-1:0] exp_byte(input logic [1:0] m, input logic [7:0] dd);
        return (m == 2'b00) ? (ERASED_BYTE & dd) : ERASED_BYTE;
    endfunction
    task automatic op(input logic [1:0] m, input logic [ADDR_W-1:0] ad,
        input logic [DATA_W-1:0] dd, input logic hv);
        i_cpu.wr(OFF_CONTROL, {2'b00, m, 4'h2});
        i_cpu.wr({1'b0, ad}, dd);
        rd_chk({1'b0, ad}, dd);
        i_cpu.wr(OFF_CONTROL, {2'b00, m, 4'h3});
        i_cpu.idle(HV_CYC);
        pump_chk({hv, 2'b00});
        i_cpu.wr(OFF_CONTROL, ZERO_BYTE);
        rd_chk(OFF_CONTROL, {2'b00, m, 4'h2});
        i_cpu.wr(OFF_CONTROL, ZERO_BYTE);
        i_cpu.idle(2);
    endtask
    initial begin
        void'($urandom(32'hEC0133DF));
        repeat (4) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd_chk(OFF_CONTROL, ZERO_BYTE);
        rd_chk(OFF_ARRAY_CONFIG, NV_RESET);
        rd_chk(10'h3FF, ZERO_BYTE);
        #1 chk(cfg, NV_RESET);
        @(posedge sys_clk_i);
        $display("reset test done");
        i_cpu.wr(OFF_CONTROL, 8'h80);
        i_cpu.idle(2);
        pump_chk(3'b010);
        i_cpu.wr(OFF_CONTROL, 8'h40);
        i_cpu.idle(2);
        pump_chk(3'b001);
        i_cpu.wr(OFF_CONTROL, ZERO_BYTE);
        i_cpu.idle(4);
        $display("pump test done");
        wait_i <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wait_i <= 1'($urandom);
            a = ADDR_W'($urandom);
            d = DATA_W'($urandom);
            op(2'b00, a, d, 1'b1);
            t = (m == 1) ? a : (m == 2) ? {a[8:7], 7'($urandom)} : ADDR_W'($urandom);
            if (m != 0) begin
                op(m[1:0], t, d, 1'b1);
            end
            rd_chk({1'b0, a}, exp_byte(m[1:0], d));
            rd_chk(OFF_SIDE_STATUS, {5'h00, wait_i, 2'b00});
        end
        wait_i <= 1'b0;
        $display("mode test done");
        a = ADDR_W'($urandom);
        d = {4'h1, 4'h1 << a[8:7]};
        i_cpu.wr(OFF_NV_CONFIG, d);
        nv_chk(d);
        op(2'b00, a, ZERO_BYTE, 1'b0);
        rd_chk({1'b0, a}, ERASED_BYTE);
        i_cpu.wr(OFF_NV_CONFIG, NV_RESET);
        nv_chk(NV_RESET);
        $display("protect test done");
        i_cpu.wr(OFF_CONTROL, 8'h02);
        i_cpu.wr(10'h010, 8'h0F);
        i_cpu.wr(OFF_CONTROL, 8'h03);
        i_cpu.wr(OFF_CONTROL, 8'h33);
        rd_chk(OFF_CONTROL, 8'h03);
        stop_i <= 1'b1;
        i_cpu.idle(6);
        pump_chk(3'b000);
        rd_chk(OFF_CONTROL, 8'h03);
        stop_i <= 1'b0;
        i_cpu.idle(6);
        pump_chk(3'b100);
        i_cpu.wr(OFF_CONTROL, ZERO_BYTE);
        i_cpu.wr(OFF_CONTROL, ZERO_BYTE);
        rd_chk(10'h010, 8'h0F);
        $display("stop test done");
        i_cpu.wr(OFF_NV_CONFIG, ZERO_BYTE);
        nv_chk(ZERO_BYTE);
        i_cpu.wr(OFF_CONTROL, 8'h02);
        i_cpu.wr(10'h0F5, ZERO_BYTE);
        i_cpu.wr(OFF_CONTROL, 8'h03);
        rd_chk(OFF_CONTROL, 8'h02);
        i_cpu.wr(10'h010, ERASED_BYTE);
        i_cpu.wr(OFF_CONTROL, ZERO_BYTE);
        rd_chk(10'h0F5, ERASED_BYTE);
        i_cpu.wr(OFF_NV_CONFIG, 8'h1F);
        rd_chk(OFF_NV_CONFIG, ZERO_BYTE);
        $display("one-time test done");
        final_report();
    end
endmodule // tb_top

// *** src/eepc_array.sv ***
// eepc_array: byte array storage with program, byte, block and bulk erase
// assumes the controller supplies only legal, unprotected operations
`timescale 1ns/100ps
module eepc_array
    import eepc_pkg::*;
#(
    parameter int DEPTH = 512
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // operation, applied once per cycle while asserted
    input wire logic op_i,
    input wire eepc_pkg::eepc_mode_e mode_i,
    input wire logic [eepc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [eepc_pkg::DATA_W-1:0] data_i,
    // read port, combinational
    input wire logic [eepc_pkg::ADDR_W-1:0] raddr_i,
    output logic [eepc_pkg::DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [DEPTH];

    assign rdata_o = mem[raddr_i];

    // ------------------------------------------------------------
    // cells: programming only pulls bits to 0, erase sets them to 1
    // ------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
        localparam logic [ADDR_W-1:0] IDX = ADDR_W'(i);
        always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mem[i] <= ERASED_BYTE;
            end else if (op_i) begin
                unique case (mode_i)
                    EEPC_BYTE_PROG: if (addr_i == IDX) mem[i] <= mem[i] & data_i;
                    EEPC_BYTE_ERASE: if (addr_i == IDX) mem[i] <= ERASED_BYTE;
                    EEPC_BLOCK_ERASE: begin
                        if (addr_i[ADDR_W-1:BLOCK_SHIFT] == IDX[ADDR_W-1:BLOCK_SHIFT]) begin
                            mem[i] <= ERASED_BYTE;
                        end
                    end
                    EEPC_BULK_ERASE: mem[i] <= ERASED_BYTE;
                endcase
            end
        end
    end
endmodule // eepc_array

// *** src/eepc_pkg.sv ***
// eepc_pkg: constants, types and register map for the eeprom program/erase control block
// assumes a plain register port with one-cycle read latency and a byte-wide array
package eepc_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int BLOCKS = 4;
    localparam int BLOCK_SHIFT = 7;
    localparam logic [ADDR_W-1:0] SECURE_BASE = 9'h0F0;
    localparam logic [ADDR_W-1:0] SECURE_LAST = 9'h0FF;

    // ------------------------------------------------------------
    // register port: bit 9 selects the control page
    // ------------------------------------------------------------
    localparam int BUS_AW = 10;
    localparam logic [BUS_AW-1:0] OFF_CONTROL = 10'h200;
    localparam logic [BUS_AW-1:0] OFF_NV_CONFIG = 10'h201;
    localparam logic [BUS_AW-1:0] OFF_ARRAY_CONFIG = 10'h202;
    localparam logic [BUS_AW-1:0] OFF_SIDE_STATUS = 10'h203;
    localparam int CTRL_PAGE_BIT = 9;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int B_PUMP_CLK = 7;
    localparam int B_POWER_DOWN = 6;
    localparam int B_ERASE_HI = 5;
    localparam int B_ERASE_LO = 4;
    localparam int B_LATCH = 1;
    localparam int B_HV_EN = 0;

    // ------------------------------------------------------------
    // configuration register fields
    // ------------------------------------------------------------
    localparam int B_REDUNDANT = 7;
    localparam int B_ONE_TIME = 4;
    localparam int B_BP_LO = 0;
    localparam logic [DATA_W-1:0] NV_RESET = 8'h10;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    typedef enum logic [1:0] {
        EEPC_BYTE_PROG = 2'b00,
        EEPC_BYTE_ERASE = 2'b01,
        EEPC_BLOCK_ERASE = 2'b10,
        EEPC_BULK_ERASE = 2'b11
    } eepc_mode_e;

    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } eepc_bus_s;

    typedef struct packed {
        logic hv_on;
        logic pump_bus_clk;
        logic power_down;
    } eepc_pump_s;

endpackage

// *** src/eepc_sync.sv ***
// eepc_sync: two flip-flop synchroniser for asynchronous level inputs
// assumes a single destination clock and a reset already synchronised
`timescale 1ns/100ps
module eepc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // level in and out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] stage;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage <= '0;
            q_o <= '0;
        end else begin
            stage <= d_i;
            q_o <= stage;
        end
    end
endmodule // eepc_sync

// *** src/eepc_top.sv ***
// eepc_top: eeprom program/erase control with control and configuration registers
// assumes a cpu-side register port on sys_clk_i; stop request arrives asynchronously
//
// What this block does
// - pump clock select 1 picks bus clock, 0 picks rc oscillator; reset clears.
// - power down bit disables the array; reads undefined; reset clears.
// - erase bits pick program, byte, block or bulk erase; protection blocks all.
// - latch bit 1 captures writes for programming, 0 gives normal reads.
// - latch bit cannot be cleared while high voltage enable is set.
// - high voltage applies only with latch set and a valid write captured.
// - clearing latch and enable together clears only the enable.
// - reset copies nonvolatile configuration into the volatile configuration.
// - one-time protect at 0 permanently locks the 16-byte secured range.
// - reset loads the four block protect bits; 1 protects a block.
// - wait mode leaves program or erase running.
// - stop drops high voltage but keeps enable; restored at stop exit.
// - four 128-byte blocks, protect bits in ascending address order.
// - latch captures valid writes only; reads return latched data; gating.
// - erase mode is frozen while the high voltage enable is set.
// - each read of the nonvolatile register reloads the volatile register.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module eepc_top
    import eepc_pkg::*;
#(
    parameter int DEPTH = 512
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // register port
    input wire eepc_pkg::eepc_bus_s bus_i,
    output logic [eepc_pkg::DATA_W-1:0] rdata_o,
    // low power modes
    input wire logic stop_i,
    input wire logic wait_i,
    // charge pump and status
    output eepc_pkg::eepc_pump_s pump_o,
    output logic [eepc_pkg::DATA_W-1:0] mcu_config_bits_o
);
    import eepc_pkg::*;

    // ------------------------------------------------------------
    // reset release and input synchronisation
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    logic stop_s;
    logic wait_s;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // stop and wait arrive from outside this clock's logic, so they are synchronised
    eepc_sync #(.W(2)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .d_i({stop_i, wait_i}),
        .q_o({stop_s, wait_s})
    );

    // ------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------
    logic pump_clock_select;
    logic array_power_down;
    eepc_mode_e erase_mode;
    logic latch_control;
    logic high_voltage_enable;
    logic valid_write_seen;
    logic [ADDR_W-1:0] lat_addr;
    logic [DATA_W-1:0] lat_data;
    logic [DATA_W-1:0] nv_cfg;
    logic [DATA_W-1:0] array_cfg;
    logic loaded;
    logic [DATA_W-1:0] arr_rdata;
    logic [BLOCKS-1:0] block_protect_field;
    logic one_time_protect;

    wire is_array = !bus_i.addr[CTRL_PAGE_BIT];
    wire [ADDR_W-1:0] a_addr = bus_i.addr[ADDR_W-1:0];
    wire wr_ctrl = bus_i.wr && bus_i.addr == OFF_CONTROL;
    wire wr_nv = bus_i.wr && bus_i.addr == OFF_NV_CONFIG;
    wire rd_nv = bus_i.rd && bus_i.addr == OFF_NV_CONFIG;
    wire [DATA_W-1:0] wd = bus_i.wdata;

    assign block_protect_field = array_cfg[B_BP_LO +: BLOCKS];
    assign one_time_protect = array_cfg[B_ONE_TIME];

    // secured range no longer counts as a valid array write once armed
    wire in_secure = a_addr >= SECURE_BASE && a_addr <= SECURE_LAST;
    wire valid_wr = bus_i.wr && is_array && !(in_secure && !one_time_protect);

    // ------------------------------------------------------------
    // protection check on the latched target
    // ------------------------------------------------------------
    // one hit per 128-byte block, lowest block at the lowest addresses
    logic [BLOCKS-1:0] block_hit;
    for (genvar b = 0; b < BLOCKS; b++) begin : g_block
        localparam logic [ADDR_W-BLOCK_SHIFT-1:0] BLK = (ADDR_W-BLOCK_SHIFT)'(b);
        assign block_hit[b] = block_protect_field[b]
            && lat_addr[ADDR_W-1:BLOCK_SHIFT] == BLK;
    end

    logic blocked;
    always_comb begin
        blocked = |block_hit;
        if (erase_mode == EEPC_BULK_ERASE && |block_protect_field) begin
            blocked = 1'b1;
        end
        if (!one_time_protect) begin
            if (erase_mode == EEPC_BULK_ERASE || erase_mode == EEPC_BLOCK_ERASE) begin
                blocked = 1'b1;
            end
        end
    end

    // high voltage drops in stop and comes back with the bit still set
    wire hv_on = high_voltage_enable && latch_control && valid_write_seen
                 && !stop_s && !blocked;
    // wait mode has no effect on the operation in progress
    // power down freezes the cells; array reads through it are not trusted
    wire array_op = hv_on && !array_power_down;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // with the latch set, control writes are dropped until an array write has been captured
    wire ctrl_ok = wr_ctrl && (!latch_control || valid_write_seen);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pump_clock_select <= 1'b0;
        end else if (ctrl_ok) begin
            pump_clock_select <= wd[B_PUMP_CLK];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            array_power_down <= 1'b0;
        end else if (ctrl_ok) begin
            array_power_down <= wd[B_POWER_DOWN];
        end
    end

    // the mode must not move under a running operation
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            erase_mode <= EEPC_BYTE_PROG;
        end else if (ctrl_ok && !high_voltage_enable) begin
            erase_mode <= eepc_mode_e'({wd[B_ERASE_HI], wd[B_ERASE_LO]});
        end
    end

    // clearing both only clears the enable; latch held while enable set
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            latch_control <= 1'b0;
        end else if (ctrl_ok && (wd[B_LATCH] || !high_voltage_enable)) begin
            latch_control <= wd[B_LATCH];
        end
    end

    // the enable needs the latch, old or newly written
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            high_voltage_enable <= 1'b0;
        end else if (ctrl_ok) begin
            high_voltage_enable <= wd[B_HV_EN] && (latch_control || wd[B_LATCH]);
        end
    end

    // ------------------------------------------------------------
    // address/data latch
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            valid_write_seen <= 1'b0;
        end else if (!latch_control) begin
            // dropping the latch forgets the capture, so each sequence starts clean
            valid_write_seen <= 1'b0;
        end else if (valid_wr && !high_voltage_enable) begin
            valid_write_seen <= 1'b1;
        end
    end

    // a later valid write replaces the earlier address and data
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lat_addr <= '0;
            lat_data <= ZERO_BYTE;
        end else if (latch_control && valid_wr && !high_voltage_enable) begin
            lat_addr <= a_addr;
            lat_data <= wd;
        end
    end

    // ------------------------------------------------------------
    // nonvolatile and volatile configuration
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nv_cfg <= NV_RESET;
        end else if (wr_nv && one_time_protect && !high_voltage_enable) begin
            // direct store stands in for byte program/erase of the cell;
            // once armed, the protect bit can only stay at zero
            nv_cfg <= {wd[DATA_W-1:B_ONE_TIME+1], wd[B_ONE_TIME] & nv_cfg[B_ONE_TIME],
                       wd[B_ONE_TIME-1:0]};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            array_cfg <= NV_RESET;
            loaded <= 1'b0;
        end else if (!loaded || rd_nv) begin
            // first cycle after release stands in for the load at reset
            array_cfg <= nv_cfg;
            loaded <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // array
    // ------------------------------------------------------------
    eepc_array #(.DEPTH(DEPTH)) u_array (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .op_i(array_op),
        .mode_i(erase_mode),
        .addr_i(lat_addr),
        .data_i(lat_data),
        .raddr_i(a_addr),
        .rdata_o(arr_rdata)
    );

    // ------------------------------------------------------------
    // read data and outputs
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_rdata;
    always_comb begin
        next_rdata = ZERO_BYTE;
        if (is_array) begin
            next_rdata = latch_control ? lat_data : arr_rdata;
        end else begin
            unique case (bus_i.addr)
                OFF_CONTROL: begin
                    next_rdata[B_PUMP_CLK] = pump_clock_select;
                    next_rdata[B_POWER_DOWN] = array_power_down;
                    next_rdata[B_ERASE_HI] = erase_mode[1];
                    next_rdata[B_ERASE_LO] = erase_mode[0];
                    next_rdata[B_LATCH] = latch_control;
                    next_rdata[B_HV_EN] = high_voltage_enable;
                end
                OFF_NV_CONFIG: next_rdata = nv_cfg;
                OFF_ARRAY_CONFIG: next_rdata = array_cfg;
                OFF_SIDE_STATUS: next_rdata = {5'h00, wait_s, valid_write_seen, hv_on};
                default: next_rdata = ZERO_BYTE;
            endcase
        end
    end

    // every output leaves straight from a flip-flop
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= ZERO_BYTE;
        end else begin
            rdata_o <= bus_i.rd ? next_rdata : ZERO_BYTE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pump_o <= '0;
        end else begin
            pump_o.hv_on <= hv_on;
            pump_o.pump_bus_clk <= pump_clock_select;
            pump_o.power_down <= array_power_down;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mcu_config_bits_o <= ZERO_BYTE;
        end else begin
            mcu_config_bits_o <= array_cfg;
        end
    end
endmodule // eepc_top
